// ===== core/pai_access_top.sv
// Purpose: I2C target front end with per-port alias decoders and an indirect access window
// Assumes: scl and sda arrive asynchronously; sda is open drain
// Notes on behaviour
// (R1) Port 1 alias register bits 7:1 hold a target address reaching port 1 registers.
// (R2) Port 2 alias register bits 7:1 hold a target address reaching port 2 registers.
// (R3) Port 3 alias register bits 7:1 hold a target address reaching port 3 registers.
// (R4) An alias field of zero disables that decoder; nothing is claimed through it.
// (R5) Shared registers are also reachable through any enabled alias address.
// (R6) Alias bit 0 reads zero; alias registers reset to zero, all disabled.
// (R7) Hidden control, offset and data registers sit at B0, B1, B2.
// (R8) Hidden control selects pattern generator, CSI-2 timing or analog set.
// (R9) Host writes control, then offset, then data to write a hidden register.
// (R10) Host writes control, then offset, then reads data to read one.
// (R11) With auto-increment, each data write stores to the next hidden offset.
// (R12) With auto-increment, each data read returns the next hidden offset.
// (R13) Port 0 alias register at F8 works alike; zero disables it.
// (R14) Without alias, the port select register picks which port's registers respond.
// (R15) Hidden offset steps by one per data access with auto-increment only; aliases leave port select untouched.
`timescale 1ns/1ps
`include "pai_defs.svh"
module pai_access_top #(
	parameter logic [6:0] DEV_ADDR = `PAI_DEV_ADDR_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic [1:0] o_active_port,
	output logic o_via_alias,
	output pai_pkg::pai_block_t o_hidden_block
);
	import pai_pkg::*;

	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	pai_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic [1:0] port_q;
	logic have_off_q;
	logic [7:0] ptr_q;
	logic [7:0] alias_q [0:3];
	logic [1:0] psel_q;
	logic ainc_q;
	pai_block_t hsel_q;
	logic [7:0] hptr_q;
	logic [7:0] shared_mem [0:255];
	logic [7:0] port_mem [0:255];
	logic [7:0] hid_mem [0:1023];
	logic [3:0] alias_hit;
	logic main_hit, claim;
	logic [1:0] claim_port;
	logic ev_addr_done, ev_aack_end, ev_rx_done, ev_wack_end, ev_load, ev_tx_fall, ev_nack;
	logic [7:0] rd_data;
	logic in_port_range, rd_in_port;
	pai_wr_t wr;

	// pin synchronisers, stage 3 only for edge detection
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= i_scl;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= i_sda;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	// one decoder per port, port 0 included
	for (genvar p = 0; p < 4; p++) begin : g_alias
		pai_alias_match u_match (
			.i_alias_field(alias_q[p][`PAI_ALIAS_FIELD_MSB:`PAI_ALIAS_FIELD_LSB]),
			.i_target(shift_q[7:1]),
			.o_hit(alias_hit[p])
		); // R1 R2 R3 R13
	end

	// main address follows the port select; otherwise the lowest hitting alias
	always_comb begin
		main_hit = (shift_q[7:1] == DEV_ADDR);
		claim = main_hit | (|alias_hit);
		claim_port = psel_q; // R14
		if (!main_hit) begin
			if (alias_hit[0]) begin
				claim_port = 2'h0; // R13
			end else if (alias_hit[1]) begin
				claim_port = 2'h1; // R1
			end else if (alias_hit[2]) begin
				claim_port = 2'h2; // R2
			end else begin
				claim_port = 2'h3; // R3
			end
		end
	end

	assign ev_addr_done = (state_q == PAI_ST_ADDR) && scl_fall && (cnt_q == `PAI_BITS_PER_BYTE);
	assign ev_aack_end = (state_q == PAI_ST_AACK) && scl_fall;
	assign ev_rx_done = (state_q == PAI_ST_RX) && scl_fall && (cnt_q == `PAI_BITS_PER_BYTE);
	assign ev_wack_end = (state_q == PAI_ST_WACK) && scl_fall;
	assign ev_load = (ev_aack_end && rw_q) || ((state_q == PAI_ST_MACK) && scl_fall);
	assign ev_tx_fall = (state_q == PAI_ST_TX) && scl_fall;
	assign ev_nack = (state_q == PAI_ST_MACK) && scl_rise && sda_s2_q;

	// serial engine
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q <= PAI_ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
		end else if (bus_start) begin
			state_q <= PAI_ST_ADDR;
			cnt_q <= 4'h0;
		end else if (bus_stop) begin
			state_q <= PAI_ST_IDLE;
		end else begin
			unique case (state_q)
				PAI_ST_IDLE: begin
				end
				PAI_ST_ADDR, PAI_ST_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s2_q};
						cnt_q <= 4'(cnt_q + 4'h1);
					end
					if (ev_addr_done) begin
						state_q <= claim ? PAI_ST_AACK : PAI_ST_IDLE; // R4
						cnt_q <= 4'h0;
					end
					if (ev_rx_done) begin
						state_q <= PAI_ST_WACK;
						cnt_q <= 4'h0;
					end
				end
				PAI_ST_AACK: begin
					if (ev_aack_end) begin
						state_q <= rw_q ? PAI_ST_TX : PAI_ST_RX;
						cnt_q <= rw_q ? 4'h1 : 4'h0;
					end
				end
				PAI_ST_WACK: begin
					if (ev_wack_end) begin
						state_q <= PAI_ST_RX;
					end
				end
				PAI_ST_TX: begin
					if (ev_tx_fall) begin
						if (cnt_q == `PAI_BITS_PER_BYTE) begin
							state_q <= PAI_ST_MACK;
							cnt_q <= 4'h0;
						end else begin
							cnt_q <= 4'(cnt_q + 4'h1);
						end
					end
				end
				PAI_ST_MACK: begin
					if (ev_nack) begin
						state_q <= PAI_ST_IDLE;
					end else if (scl_fall) begin
						state_q <= PAI_ST_TX;
						cnt_q <= 4'h1;
					end
				end
				default: begin
					state_q <= PAI_ST_IDLE;
				end
			endcase
		end
	end

	// open-drain drive: oe high pulls sda low
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_sda_oe <= 1'b0;
			o_sda_out <= 1'b0;
			tx_q <= 8'h00;
		end else if (bus_start || bus_stop) begin
			o_sda_oe <= 1'b0;
		end else if ((ev_addr_done && claim) || ev_rx_done) begin
			o_sda_oe <= 1'b1;
		end else if (ev_load) begin
			o_sda_oe <= ~rd_data[7];
			tx_q <= {rd_data[6:0], 1'b0};
		end else if (ev_aack_end || ev_wack_end) begin
			o_sda_oe <= 1'b0;
		end else if (ev_tx_fall) begin
			o_sda_oe <= (cnt_q == `PAI_BITS_PER_BYTE) ? 1'b0 : ~tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// transaction context; alias claims never touch psel_q
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rw_q <= 1'b0;
			port_q <= 2'h0;
			o_active_port <= 2'h0;
			o_via_alias <= 1'b0;
		end else if (ev_addr_done && claim) begin
			rw_q <= shift_q[0];
			port_q <= claim_port; // R15
			o_active_port <= claim_port;
			o_via_alias <= ~main_hit;
		end
	end

	// register offset pointer, steps after each data byte
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			have_off_q <= 1'b0;
			ptr_q <= 8'h00;
		end else if (ev_addr_done) begin
			have_off_q <= 1'b0;
		end else if (ev_rx_done && !have_off_q) begin
			have_off_q <= 1'b1;
			ptr_q <= shift_q;
		end else if (ev_rx_done || ev_load) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	assign wr = '{en: ev_rx_done && have_off_q, off: ptr_q, data: shift_q, port: port_q};
	assign in_port_range = (wr.off >= `PAI_OFF_PORT_LO) && (wr.off <= `PAI_OFF_PORT_HI);

	// alias, port select and hidden control registers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 4; i++) begin
				alias_q[i] <= `PAI_ALIAS_RST; // R6
			end
			psel_q <= `PAI_PSEL_RST;
			ainc_q <= 1'b0;
			hsel_q <= pai_block_t'(`PAI_CTL_SEL_RST);
		end else if (wr.en) begin
			if (wr.off[7:2] == `PAI_ALIAS_BASE_HI) begin
				alias_q[wr.off[1:0]] <= {wr.data[7:1], 1'b0}; // R6
			end
			if (wr.off == `PAI_OFF_PORT_SELECT) begin
				psel_q <= wr.data[`PAI_PSEL_MSB:0]; // R14
			end
			if (wr.off == `PAI_OFF_HID_CTL) begin
				ainc_q <= wr.data[`PAI_CTL_AINC_BIT]; // R7
				hsel_q <= pai_block_t'(wr.data[`PAI_CTL_SEL_MSB:`PAI_CTL_SEL_LSB]); // R8
			end
		end
	end

	assign o_hidden_block = hsel_q;

	// hidden offset: loaded by B1, stepped by one per data access under auto-increment
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			hptr_q <= `PAI_HID_PTR_RST;
		end else if (wr.en && (wr.off == `PAI_OFF_HID_PTR)) begin
			hptr_q <= wr.data; // R7
		end else if (ainc_q && wr.en && (wr.off == `PAI_OFF_HID_DATA)) begin
			hptr_q <= hptr_q + 8'h01; // R11 R15
		end else if (ainc_q && ev_load && (ptr_q == `PAI_OFF_HID_DATA)) begin
			hptr_q <= hptr_q + 8'h01; // R12 R15
		end
	end

	// storage arrays
	always_ff @(posedge i_core_clk) begin
		if (wr.en && (wr.off == `PAI_OFF_HID_DATA) && (hsel_q != PAI_BLK_NONE)) begin
			hid_mem[{hsel_q, hptr_q}] <= wr.data; // R11
		end
		if (wr.en && in_port_range) begin
			port_mem[{wr.port, wr.off[5:0]}] <= wr.data; // R1 R2 R3
		end else if (wr.en) begin
			shared_mem[wr.off] <= wr.data; // R5
		end
	end

	// read mux for the byte about to be shifted out
	always_comb begin
		rd_in_port = (ptr_q >= `PAI_OFF_PORT_LO) && (ptr_q <= `PAI_OFF_PORT_HI);
		rd_data = shared_mem[ptr_q]; // R5
		if (rd_in_port) begin
			rd_data = port_mem[{port_q, ptr_q[5:0]}]; // R14
		end
		if (ptr_q[7:2] == `PAI_ALIAS_BASE_HI) begin
			rd_data = alias_q[ptr_q[1:0]];
		end
		unique case (ptr_q)
			`PAI_OFF_PORT_SELECT: rd_data = {6'h00, psel_q};
			`PAI_OFF_HID_CTL: rd_data = {4'h0, hsel_q, 1'b0, ainc_q};
			`PAI_OFF_HID_PTR: rd_data = hptr_q;
			`PAI_OFF_HID_DATA: begin
				rd_data = (hsel_q == PAI_BLK_NONE) ? 8'h00 : hid_mem[{hsel_q, hptr_q}]; // R12
			end
			default: begin
			end
		endcase
	end

endmodule : pai_access_top

// ===== core/pai_alias_match.sv
// Purpose: one port alias decoder
// Assumes: target address and alias field are both 7 bits
// Notes: a zero field never matches
`timescale 1ns/1ps
module pai_alias_match (
	input wire logic [6:0] i_alias_field,
	input wire logic [6:0] i_target,
	output logic o_hit
);
	import pai_pkg::*;

	assign o_hit = (i_alias_field != 7'h00) && (i_alias_field == i_target); // R4

endmodule : pai_alias_match

// ===== core/pai_defs.svh
// Purpose: offsets, field positions and reset values of the alias and indirect access front end
// Assumes: 8-bit register space reached over the I2C target pins
// Notes: included by the top module
`ifndef PAI_DEFS_SVH
`define PAI_DEFS_SVH

// main register space offsets
`define PAI_OFF_PORT_SELECT 8'h4C
`define PAI_OFF_PORT_LO 8'h4D
`define PAI_OFF_PORT_HI 8'h7F
`define PAI_OFF_HID_CTL 8'hB0
`define PAI_OFF_HID_PTR 8'hB1
`define PAI_OFF_HID_DATA 8'hB2
`define PAI_OFF_PORT0_ALIAS 8'hF8
`define PAI_OFF_PORT1_ALIAS 8'hF9
`define PAI_OFF_PORT2_ALIAS 8'hFA
`define PAI_OFF_PORT3_ALIAS 8'hFB
// alias block occupies F8..FB, matched on offset bits 7:2
`define PAI_ALIAS_BASE_HI 6'h3E

// field positions
`define PAI_ALIAS_FIELD_MSB 7
`define PAI_ALIAS_FIELD_LSB 1
`define PAI_CTL_AINC_BIT 0
`define PAI_CTL_SEL_MSB 3
`define PAI_CTL_SEL_LSB 2
`define PAI_PSEL_MSB 1

// reset values
`define PAI_ALIAS_RST 8'h00
`define PAI_PSEL_RST 2'h0
`define PAI_CTL_SEL_RST 2'h0
`define PAI_HID_PTR_RST 8'h00
// main target address, arbitrary value
`define PAI_DEV_ADDR_DEF 7'h3D

// bit counts of the serial engine
`define PAI_BITS_PER_BYTE 4'h8

`endif

// ===== core/pai_pkg.sv
// Purpose: shared types of the alias and indirect access front end
// Assumes: constants live in pai_defs.svh
// Notes: states are one-hot
package pai_pkg;

	typedef enum logic [6:0] {
		PAI_ST_IDLE = 7'h01,
		PAI_ST_ADDR = 7'h02,
		PAI_ST_AACK = 7'h04,
		PAI_ST_RX = 7'h08,
		PAI_ST_WACK = 7'h10,
		PAI_ST_TX = 7'h20,
		PAI_ST_MACK = 7'h40
	} pai_state_t;

	typedef enum logic [1:0] {
		PAI_BLK_PATGEN = 2'h0,
		PAI_BLK_CSI_TIMING = 2'h1,
		PAI_BLK_ANALOG = 2'h2,
		PAI_BLK_NONE = 2'h3
	} pai_block_t;

	typedef struct packed {
		logic en;
		logic [7:0] off;
		logic [7:0] data;
		logic [1:0] port;
	} pai_wr_t;

endpackage : pai_pkg

// ===== dv/i2c_port_alias_indirect_access_bench.sv
// Purpose: self-checking bench for aliases and the hidden window
// Assumes: main target address 7'h3D; aliases 7'h10..7'h13
// Notes: all bus traffic goes through the host model
`timescale 1ns/1ps
module i2c_port_alias_indirect_access_bench;
	import pai_pkg::*;
	localparam logic [6:0] MAIN = 7'h3D;
	logic clk, rst_n, scl, sda_low, sda, oe, via, ack;
	logic [1:0] port;
	logic [7:0] rv, rv2;
	pai_block_t blk;
	int fail_count, checked, cyc;
	assign sda = ~(sda_low | oe);
	pai_access_top #(.DEV_ADDR(MAIN)) u_pai_access_top (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .o_active_port(port),
		.o_via_alias(via), .o_hidden_block(blk));
	pai_i2c_host u_pai_i2c_host (.i_core_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk8
	task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d);
		u_pai_i2c_host.start(1'b0);
		u_pai_i2c_host.put({a, 1'b0}, ack);
		if (ack === 1'b1) begin
			u_pai_i2c_host.put(off, ack);
			u_pai_i2c_host.put(d, ack);
		end
		u_pai_i2c_host.stop();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d);
		u_pai_i2c_host.start(1'b0);
		u_pai_i2c_host.put({a, 1'b0}, ack);
		u_pai_i2c_host.put(off, ack);
		u_pai_i2c_host.start(1'b1);
		u_pai_i2c_host.put({a, 1'b1}, ack);
		u_pai_i2c_host.get(1'b1, d);
		u_pai_i2c_host.stop();
	endtask : rd
	// two bytes in one read, host acks the first
	task automatic rd_pair(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d0,
		output logic [7:0] d1);
		u_pai_i2c_host.start(1'b0);
		u_pai_i2c_host.put({a, 1'b0}, ack);
		u_pai_i2c_host.put(off, ack);
		u_pai_i2c_host.start(1'b1);
		u_pai_i2c_host.put({a, 1'b1}, ack);
		u_pai_i2c_host.get(1'b0, d0);
		u_pai_i2c_host.get(1'b1, d1);
		u_pai_i2c_host.stop();
	endtask : rd_pair
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int p = 0; p < 4; p++) begin
			rd(MAIN, 8'hF8 + 8'(p), rv);
			chk8("alias reset", 8'h00, rv);
		end
		wr(7'h00, 8'h10, 8'h01);
		chk8("zero alias ack", 8'h00, {7'h0, ack});
		$display("test reset done");
		for (int p = 0; p < 4; p++) begin
			wr(MAIN, 8'hF8 + 8'(p), {7'h10 + 7'(p), 1'b1});
			rd(MAIN, 8'hF8 + 8'(p), rv);
			chk8("alias reg", {7'h10 + 7'(p), 1'b0}, rv);
		end
		rd_pair(MAIN, 8'hF8, rv, rv2);
		chk8("alias pair first", 8'h20, rv);
		chk8("alias pair second", 8'h22, rv2);
		wr(MAIN, 8'h4C, 8'h00);
		wr(MAIN, 8'h10, 8'h5A);
		for (int p = 0; p < 4; p++) begin
			wr(7'h10 + 7'(p), 8'h4D, 8'hA0 + 8'(p));
			chk8("active port", 8'(p), {6'h0, port});
			chk8("via alias", 8'h01, {7'h0, via});
		end
		rd(MAIN, 8'h4D, rv);
		chk8("paged read", 8'hA0, rv);
		chk8("via alias", 8'h00, {7'h0, via});
		rd(MAIN, 8'h4C, rv);
		chk8("port select", 8'h00, rv);
		wr(MAIN, 8'h4C, 8'h02);
		rd(MAIN, 8'h4D, rv);
		chk8("paged read", 8'hA2, rv);
		for (int p = 0; p < 4; p++) begin
			rd(7'h10 + 7'(p), 8'h4D, rv);
			chk8("alias port reg", 8'hA0 + 8'(p), rv);
			rd(7'h10 + 7'(p), 8'h10, rv);
			chk8("alias shared reg", 8'h5A, rv);
		end
		$display("test alias done");
		for (int b = 0; b < 3; b++) begin
			wr(MAIN, 8'hB0, {4'h0, 2'(b), 2'h1});
			chk8("hidden block", 8'(b), {6'h0, blk});
			wr(MAIN, 8'hB1, 8'hFE);
			for (int i = 0; i < 3; i++) wr(MAIN, 8'hB2, {4'(b + 1), 4'(i)});
		end
		for (int b = 0; b < 3; b++) begin
			wr(MAIN, 8'hB0, {4'h0, 2'(b), 2'h1});
			wr(MAIN, 8'hB1, 8'hFE);
			for (int i = 0; i < 3; i++) begin
				rd(MAIN, 8'hB2, rv);
				chk8("hidden data", {4'(b + 1), 4'(i)}, rv);
			end
			rd(MAIN, 8'hB1, rv);
			chk8("hidden offset", 8'h01, rv);
		end
		wr(MAIN, 8'hB0, 8'h00);
		wr(MAIN, 8'hB1, 8'hFE);
		for (int i = 0; i < 2; i++) begin
			rd(MAIN, 8'hB2, rv);
			chk8("hidden no step", 8'h10, rv);
		end
		rd(MAIN, 8'hB1, rv);
		chk8("hidden offset held", 8'hFE, rv);
		wr(MAIN, 8'hB0, 8'h0D);
		chk8("hidden block", 8'h03, {6'h0, blk});
		rd(MAIN, 8'hB2, rv);
		chk8("no block data", 8'h00, rv);
		$display("test hidden done");
		tally_and_finish();
	end
endmodule : i2c_port_alias_indirect_access_bench

// ===== dv/pai_access_top_sva.sv
// Purpose: port level checks of the alias and indirect access front end
// Assumes: single clock, synchronous active-low reset
// Notes: bound to pai_access_top
`timescale 1ns/1ps
module pai_access_top_sva (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic [1:0] o_active_port,
	input wire logic o_via_alias,
	input wire pai_pkg::pai_block_t o_hidden_block
);
	import pai_pkg::*;
	logic [7:0] oe_cnt_q;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !o_sda_oe) begin
			oe_cnt_q <= 8'h00;
		end else if (oe_cnt_q != 8'hFF) begin
			oe_cnt_q <= oe_cnt_q + 8'h01;
		end
	end
	reset_state_a: assert property ($rose(i_rst_n) |-> !o_sda_oe && !o_via_alias
		&& o_active_port == 2'h0 && o_hidden_block == PAI_BLK_PATGEN) else $error("reset state");
	sda_low_a: assert property (o_sda_out == 1'b0) else $error("sda value");
	oe_edge_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
		else $error("sda moved near scl high");
	oe_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
		else $error("drive too short");
	sync_delay_a: assert property ($fell(i_scl) |-> $stable(o_sda_oe) [*2])
		else $error("drive ahead of sync");
	scl_quiet_a: assert property ($rose(i_scl) |-> $stable(o_sda_oe) [*6])
		else $error("drive moved while scl high");
	claim_ack_a: assert property (($changed(o_active_port) || $changed(o_via_alias))
		|-> ##[0:40] o_sda_oe) else $error("claim without ack");
	stuck_drive_a: assert property (oe_cnt_q != 8'hFF) else $error("sda held too long");
	cover property ($rose(o_via_alias));
	cover property (o_hidden_block == PAI_BLK_ANALOG);
	cover property ($rose(o_sda_oe));
endmodule : pai_access_top_sva
bind pai_access_top pai_access_top_sva u_pai_access_top_sva (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
	.o_sda_oe(o_sda_oe), .o_active_port(o_active_port), .o_via_alias(o_via_alias),
	.o_hidden_block(o_hidden_block));

// ===== dv/pai_i2c_host.sv
// Purpose: I2C bus master model for the target pins
// Assumes: sda wire resolved by the bench with a pull-up
// Notes: pins change at the falling clock edge only
`timescale 1ns/1ps
module pai_i2c_host (
	input wire logic i_core_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : tick
	// sda moves only after scl has been low 8 cycles
	task automatic bit_io(input logic b, output logic s);
		o_sda_low = ~b;
		tick(8);
		o_scl = 1'b1;
		tick(4);
		s = i_sda;
		tick(4);
		o_scl = 1'b0;
		tick(8);
	endtask : bit_io
	task automatic start(input logic rep);
		if (rep) begin
			o_sda_low = 1'b0;
			tick(8);
			o_scl = 1'b1;
			tick(8);
		end
		o_sda_low = 1'b1;
		tick(8);
		o_scl = 1'b0;
		tick(8);
	endtask : start
	task automatic stop();
		o_sda_low = 1'b1;
		tick(8);
		o_scl = 1'b1;
		tick(8);
		o_sda_low = 1'b0;
		tick(8);
	endtask : stop
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put
	task automatic get(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
	endtask : get
endmodule : pai_i2c_host
